// File: cots_gate_drv.sv
// gate driver model: senses the four output pins as the power stage does
`timescale 1ns/1ns
module cots_gate_drv (
   input wire logic clk_sys,
   input wire logic [3:0] pin,
   input wire logic [3:0] oe,
   output logic [3:0] gate
);
   logic [3:0] last_r;
   // a released pin has no pull, so it shows a level that flips every cycle
   assign gate = (pin & oe) | (~last_r & ~oe);
   always_ff @(posedge clk_sys) begin
      last_r <= gate;
   end
endmodule : cots_gate_drv

// File: cots_pkg.sv
// constants, types and field layout of the complementary output timing and steering block
// What this block does
// RULE1 - shutdown-source bit 3 set: low logic cell two output forces shutdown
// RULE2 - shutdown-source bit 2 set: low comparator two output forces shutdown
// RULE3 - shutdown-source bit 1 set: low comparator one output forces shutdown
// RULE4 - shutdown-source bit 0 set: low selected input pin forces shutdown
// RULE5 - steering bits 7..4 hold static levels for outputs d, c, b, a
// RULE6 - steering bit set: output carries its waveform with its own polarity
// RULE7 - steering bit clear: output carries its static level
// RULE8 - rise dead-band select clear: primary delayed by rise count in clocks
// RULE9 - rise dead-band select set: rise count runs in delay-chain periods
// RULE10 - fall dead-band select clear: complementary delayed by fall count in clocks
// RULE11 - fall dead-band select set: fall count runs in delay-chain periods
// RULE12 - after a rising event, falling inputs ignored for rise blanking count
// RULE13 - after a falling event, rising inputs ignored for fall blanking count
// RULE14 - rising edge event postponed by rise phase count clocks
// RULE15 - count registers not reset, keep value, top two bits read zero
// RULE16 - shutdown enables and steering bits clear on every reset, upper bits zero
// RULE17 - falling edge event postponed by fall phase count clocks
// RULE18 - in shutdown each pair follows override: high, low, released, inactive level
// RULE19 - enabled sources are or-ed; shutdown state updates on next clock
package cots_pkg;
   localparam logic [7:0] OFS_SD_EN = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STEER = 8'h08;
   localparam logic [7:0] OFS_CNT0 = 8'h0c;
   localparam logic [7:0] OFS_CNT_STEP = 8'h04;
   localparam logic [7:0] OFS_IRQ_STS = 8'h24;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
   localparam logic [7:0] OFS_STATE = 8'h2c;
   localparam int CNT_W = 6;
   localparam int CNT_NUM = 6;
   localparam int CI_DBR = 0;
   localparam int CI_DBF = 1;
   localparam int CI_BLKR = 2;
   localparam int CI_BLKF = 3;
   localparam int CI_PHR = 4;
   localparam int CI_PHF = 5;
   localparam int SD_EN_W = 4;
   localparam int STR_LSB = 0;
   localparam int SDAT_LSB = 4;
   localparam int CTRL_W = 12;
   localparam int EV_W = 3;
   localparam int EV_SHUTDOWN = 0;
   localparam int EV_RISE = 1;
   localparam int EV_FALL = 2;
   localparam logic [SD_EN_W-1:0] SD_EN_RST = 4'h0;
   localparam logic [7:0] STEER_RST = 8'h00;
   localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
   localparam logic [EV_W-1:0] EV_RST = 3'h0;
   localparam logic [1:0] OVR_HIGH = 2'h3;
   localparam logic [1:0] OVR_LOW = 2'h2;
   localparam logic [1:0] OVR_RELEASE = 2'h1;
   localparam logic [1:0] OVR_INACTIVE = 2'h0;
   typedef struct packed {
      logic [1:0] override_level_bd;
      logic [1:0] override_level_ac;
      logic fall_deadband_src_sel;
      logic rise_deadband_src_sel;
      logic [1:0] unused;
      logic [3:0] polarity;
   } cots_ctrl_type;
   typedef struct packed {
      logic oe;
      logic lvl;
   } cots_pin_type;
   typedef enum logic [1:0] {
      DB_IDLE = 2'h0,
      DB_RISE = 2'h1,
      DB_FALL = 2'h2
   } cots_db_type;
endpackage : cots_pkg

// File: cots_sva.sv
// port-level assertion checker for the timing and steering block
`timescale 1ns/1ns
module cots_sva #(
   parameter int CNT_W = cots_pkg::CNT_W
) (
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic LOGIC_CELL_TWO_OUT,
   input wire logic COMPARATOR_ONE_OUT,
   input wire logic COMPARATOR_TWO_OUT,
   input wire logic SELECTED_PIN_IN,
   input wire logic OUTPUT_A,
   input wire logic OUTPUT_B,
   input wire logic OUTPUT_C,
   input wire logic OUTPUT_D,
   input wire logic OUTPUT_A_OE,
   input wire logic OUTPUT_B_OE,
   input wire logic OUTPUT_C_OE,
   input wire logic OUTPUT_D_OE,
   input wire logic SHUTDOWN_ACTIVE
);
   logic [3:0] sd_r;
   logic [7:0] st_r;
   cots_pkg::cots_ctrl_type ctrl_r;
   logic wr;
   logic rd;
   logic [3:0] src;
   logic [3:0] pin;
   // shadows follow accepted writes only, so refused writes leave them alone
   assign wr = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
   assign rd = PREADY && !PWRITE;
   assign src = {LOGIC_CELL_TWO_OUT, COMPARATOR_TWO_OUT, COMPARATOR_ONE_OUT, SELECTED_PIN_IN};
   assign pin = {OUTPUT_D, OUTPUT_C, OUTPUT_B, OUTPUT_A};
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         sd_r <= 4'h0;
         st_r <= 8'h00;
         ctrl_r <= '0;
      end else if (wr) begin
         if (PADDR == cots_pkg::OFS_SD_EN) sd_r <= PWDATA[3:0];
         if (PADDR == cots_pkg::OFS_STEER) st_r <= PWDATA[7:0];
         if (PADDR == cots_pkg::OFS_CTRL) ctrl_r <= PWDATA[11:0];
      end
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   sd_enter_a: assert property ((sd_r & ~src) != 4'h0 |=> SHUTDOWN_ACTIVE)
      else $error("shutdown not entered");
   sd_leave_a: assert property ((sd_r & ~src) == 4'h0 |=> !SHUTDOWN_ACTIVE)
      else $error("shutdown without enabled source");
   static_lvl_a: assert property (!$past(SHUTDOWN_ACTIVE) |->
      ((pin ^ $past(st_r[7:4])) & ~$past(st_r[3:0])) == 4'h0)
      else $error("static level wrong");
   ovr_high_a: assert property ($past(SHUTDOWN_ACTIVE) &&
      $past(ctrl_r.override_level_ac) == cots_pkg::OVR_HIGH |->
      OUTPUT_A && OUTPUT_C && OUTPUT_A_OE && OUTPUT_C_OE)
      else $error("override high wrong");
   ovr_low_a: assert property ($past(SHUTDOWN_ACTIVE) &&
      $past(ctrl_r.override_level_bd) == cots_pkg::OVR_LOW |->
      !OUTPUT_B && !OUTPUT_D && OUTPUT_B_OE && OUTPUT_D_OE)
      else $error("override low wrong");
   ovr_release_a: assert property ($past(SHUTDOWN_ACTIVE) &&
      $past(ctrl_r.override_level_ac) == cots_pkg::OVR_RELEASE |->
      !OUTPUT_A_OE && !OUTPUT_C_OE)
      else $error("override release wrong");
   ready_wait_a: assert property (PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY)
      else $error("ready timing wrong");
   ready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   err_map_a: assert property (PREADY |->
      PSLVERR == (PADDR > cots_pkg::OFS_STATE || PADDR[1:0] != 2'h0))
      else $error("slave error wrong");
   rdata_idle_a: assert property (!PREADY || PSLVERR |-> PRDATA == 32'h0)
      else $error("read data outside read");
   cnt_top_a: assert property (rd && PADDR >= cots_pkg::OFS_CNT0 &&
      PADDR < cots_pkg::OFS_IRQ_STS |-> (PRDATA >> CNT_W) == 32'h0)
      else $error("count upper bits set");
   sd_upper_a: assert property (rd && PADDR == cots_pkg::OFS_SD_EN |->
      PRDATA[31:4] == 28'h0)
      else $error("enable upper bits set");
endmodule : cots_sva
bind cots_top cots_sva #(.CNT_W(CNT_W)) i_sva (.CLK_SYS(CLK_SYS), .NRST(NRST), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .LOGIC_CELL_TWO_OUT(LOGIC_CELL_TWO_OUT),
   .COMPARATOR_ONE_OUT(COMPARATOR_ONE_OUT), .COMPARATOR_TWO_OUT(COMPARATOR_TWO_OUT),
   .SELECTED_PIN_IN(SELECTED_PIN_IN), .OUTPUT_A(OUTPUT_A), .OUTPUT_B(OUTPUT_B),
   .OUTPUT_C(OUTPUT_C), .OUTPUT_D(OUTPUT_D), .OUTPUT_A_OE(OUTPUT_A_OE),
   .OUTPUT_B_OE(OUTPUT_B_OE), .OUTPUT_C_OE(OUTPUT_C_OE), .OUTPUT_D_OE(OUTPUT_D_OE),
   .SHUTDOWN_ACTIVE(SHUTDOWN_ACTIVE));

// File: cots_top.sv
// complementary output timing, steering and auto-shutdown block with apb registers
`timescale 1ns/1ns
module cots_top #(
   parameter int CNT_W = cots_pkg::CNT_W
) (
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic RISE_EVENT,
   input wire logic FALL_EVENT,
   input wire logic DELAY_CHAIN_TICK,
   input wire logic LOGIC_CELL_TWO_OUT,
   input wire logic COMPARATOR_ONE_OUT,
   input wire logic COMPARATOR_TWO_OUT,
   input wire logic SELECTED_PIN_IN,
   output logic OUTPUT_A,
   output logic OUTPUT_B,
   output logic OUTPUT_C,
   output logic OUTPUT_D,
   output logic OUTPUT_A_OE,
   output logic OUTPUT_B_OE,
   output logic OUTPUT_C_OE,
   output logic OUTPUT_D_OE,
   output logic SHUTDOWN_ACTIVE,
   output logic IRQ
);

   if (CNT_W < 1 || CNT_W > 8) begin : g_bad_cnt_w
      $error("CNT_W must lie between 1 and 8");
   end

   // a count of one delay-chain element or one clock
   function automatic logic unit_tick(input logic chain_sel, input logic chain_tick);
      unit_tick = chain_sel ? chain_tick : 1'b1;
   endfunction : unit_tick

   // shutdown override first, then steering between waveform and static level
   function automatic cots_pkg::cots_pin_type pin_drive(
      input logic shut,
      input logic [1:0] ovr,
      input logic pol,
      input logic steer,
      input logic sdat,
      input logic wave
   );
      pin_drive.oe = 1'b1;
      pin_drive.lvl = 1'b0;
      if (shut) begin
         case (ovr)
            cots_pkg::OVR_HIGH: pin_drive.lvl = 1'b1; // RULE18
            cots_pkg::OVR_LOW: pin_drive.lvl = 1'b0; // RULE18
            cots_pkg::OVR_RELEASE: pin_drive.oe = 1'b0; // RULE18
            default: pin_drive.lvl = pol; // RULE18
         endcase
      end else if (steer) begin
         pin_drive.lvl = wave ^ pol; // RULE6
      end else begin
         pin_drive.lvl = sdat; // RULE7
      end
   endfunction : pin_drive

   // register file
   logic [cots_pkg::SD_EN_W-1:0] sd_en_r;
   logic [cots_pkg::SD_EN_W-1:0] sd_en_nxt;
   cots_pkg::cots_ctrl_type ctrl_r;
   cots_pkg::cots_ctrl_type ctrl_nxt;
   logic [7:0] steer_r;
   logic [7:0] steer_nxt;
   logic [CNT_W-1:0] cnt_r [cots_pkg::CNT_NUM];
   logic [CNT_W-1:0] cnt_nxt [cots_pkg::CNT_NUM];
   logic [cots_pkg::EV_W-1:0] sts_r;
   logic [cots_pkg::EV_W-1:0] sts_nxt;
   logic [cots_pkg::EV_W-1:0] mask_r;
   logic [cots_pkg::EV_W-1:0] mask_nxt;
   logic [cots_pkg::EV_W-1:0] ev;
   logic [cots_pkg::EV_W-1:0] clr;

   // bus answer
   logic pready_r;
   logic pready_nxt;
   logic pslverr_r;
   logic pslverr_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic [31:0] rd_val;
   logic hit;
   logic wr_fire;

   // timing engine
   logic sd_r;
   logic sd_nxt;
   logic [cots_pkg::SD_EN_W-1:0] src_low;
   logic [CNT_W-1:0] rblk_r;
   logic [CNT_W-1:0] rblk_nxt;
   logic [CNT_W-1:0] fblk_r;
   logic [CNT_W-1:0] fblk_nxt;
   logic [CNT_W-1:0] rph_r;
   logic [CNT_W-1:0] rph_nxt;
   logic [CNT_W-1:0] fph_r;
   logic [CNT_W-1:0] fph_nxt;
   logic [CNT_W-1:0] db_r;
   logic [CNT_W-1:0] db_nxt;
   cots_pkg::cots_db_type db_st_r;
   cots_pkg::cots_db_type db_st_nxt;
   logic prim_r;
   logic prim_nxt;
   logic comp_r;
   logic comp_nxt;
   logic rise_acc;
   logic fall_acc;
   logic rise_go;
   logic fall_go;
   logic db_tick;

   // pins
   cots_pkg::cots_pin_type pin_nxt [4];
   logic [3:0] out_r;
   logic [3:0] oe_r;
   logic [3:0] wave;
   logic irq_r;
   logic irq_nxt;

   // ---------------- apb slave, one wait state ----------------

   assign wr_fire = PSEL & PENABLE & pready_r & PWRITE & ~pslverr_r;

   always_comb begin
      hit = 1'b1;
      rd_val = 32'h0;
      case (PADDR)
         cots_pkg::OFS_SD_EN: rd_val[cots_pkg::SD_EN_W-1:0] = sd_en_r; // RULE16
         cots_pkg::OFS_CTRL: rd_val[cots_pkg::CTRL_W-1:0] = ctrl_r;
         cots_pkg::OFS_STEER: rd_val[7:0] = steer_r;
         cots_pkg::OFS_IRQ_STS: rd_val[cots_pkg::EV_W-1:0] = sts_r;
         cots_pkg::OFS_IRQ_MASK: rd_val[cots_pkg::EV_W-1:0] = mask_r;
         cots_pkg::OFS_STATE: rd_val[2:0] = {comp_r, prim_r, sd_r};
         default: hit = 1'b0;
      endcase
      for (int i = 0; i < cots_pkg::CNT_NUM; i++) begin
         if (PADDR == cots_pkg::OFS_CNT0 + 8'(i) * cots_pkg::OFS_CNT_STEP) begin
            hit = 1'b1;
            rd_val[CNT_W-1:0] = cnt_r[i]; // RULE15
         end
      end
   end

   always_comb begin
      pready_nxt = PSEL & PENABLE & ~pready_r;
      pslverr_nxt = pready_nxt & ~hit;
      prdata_nxt = (pready_nxt & ~PWRITE) ? rd_val : 32'h0;
   end

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else begin
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // ---------------- registers ----------------

   always_comb begin
      sd_en_nxt = sd_en_r;
      ctrl_nxt = ctrl_r;
      steer_nxt = steer_r;
      mask_nxt = mask_r;
      clr = '0;
      for (int i = 0; i < cots_pkg::CNT_NUM; i++) begin
         cnt_nxt[i] = cnt_r[i];
      end
      if (wr_fire) begin
         case (PADDR)
            cots_pkg::OFS_SD_EN: sd_en_nxt = PWDATA[cots_pkg::SD_EN_W-1:0];
            cots_pkg::OFS_CTRL: ctrl_nxt = PWDATA[cots_pkg::CTRL_W-1:0];
            cots_pkg::OFS_STEER: steer_nxt = PWDATA[7:0]; // RULE5
            cots_pkg::OFS_IRQ_STS: clr = PWDATA[cots_pkg::EV_W-1:0];
            cots_pkg::OFS_IRQ_MASK: mask_nxt = PWDATA[cots_pkg::EV_W-1:0];
            default: clr = '0;
         endcase
         for (int i = 0; i < cots_pkg::CNT_NUM; i++) begin
            if (PADDR == cots_pkg::OFS_CNT0 + 8'(i) * cots_pkg::OFS_CNT_STEP) begin
               cnt_nxt[i] = PWDATA[CNT_W-1:0]; // RULE15
            end
         end
      end
      ctrl_nxt.unused = 2'h0;
      // a new event beats a clear written in the same cycle
      sts_nxt = (sts_r & ~clr) | ev;
      irq_nxt = |(sts_nxt & mask_nxt);
   end

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         sd_en_r <= cots_pkg::SD_EN_RST; // RULE16
         ctrl_r <= cots_pkg::CTRL_RST;
         steer_r <= cots_pkg::STEER_RST; // RULE16
         sts_r <= cots_pkg::EV_RST;
         mask_r <= cots_pkg::EV_RST;
         irq_r <= 1'b0;
      end else begin
         sd_en_r <= sd_en_nxt;
         ctrl_r <= ctrl_nxt;
         steer_r <= steer_nxt;
         sts_r <= sts_nxt;
         mask_r <= mask_nxt;
         irq_r <= irq_nxt;
      end
   end

   // counts keep their contents through reset, so no reset branch here
   always_ff @(posedge CLK_SYS) begin
      for (int i = 0; i < cots_pkg::CNT_NUM; i++) begin
         cnt_r[i] <= cnt_nxt[i]; // RULE15
      end
   end

   // ---------------- shutdown, blanking, phase and dead-band ----------------

   assign src_low = ~{LOGIC_CELL_TWO_OUT, COMPARATOR_TWO_OUT, COMPARATOR_ONE_OUT,
                      SELECTED_PIN_IN};

   always_comb begin
      // RULE1 RULE2 RULE3 RULE4 RULE19
      sd_nxt = |(sd_en_r & src_low);
      // a blanked input is dropped, not deferred
      rise_acc = RISE_EVENT & (fblk_r == '0) & ~sd_r; // RULE13
      fall_acc = FALL_EVENT & (rblk_r == '0) & ~sd_r & ~rise_acc; // RULE12
      rblk_nxt = (rblk_r != '0) ? rblk_r - 1'b1 : rblk_r;
      fblk_nxt = (fblk_r != '0) ? fblk_r - 1'b1 : fblk_r;
      if (rise_acc) begin
         rblk_nxt = cnt_r[cots_pkg::CI_BLKR]; // RULE12
      end
      if (fall_acc) begin
         fblk_nxt = cnt_r[cots_pkg::CI_BLKF]; // RULE13
      end

      rise_go = 1'b0;
      fall_go = 1'b0;
      rph_nxt = rph_r;
      fph_nxt = fph_r;
      if (rph_r != '0) begin
         rph_nxt = rph_r - 1'b1;
         rise_go = (rph_r == CNT_W'(1)); // RULE14
      end
      if (fph_r != '0) begin
         fph_nxt = fph_r - 1'b1;
         fall_go = (fph_r == CNT_W'(1)); // RULE17
      end
      if (rise_acc) begin
         rph_nxt = cnt_r[cots_pkg::CI_PHR]; // RULE14
         rise_go = (cnt_r[cots_pkg::CI_PHR] == '0);
      end
      if (fall_acc) begin
         fph_nxt = cnt_r[cots_pkg::CI_PHF]; // RULE17
         fall_go = (cnt_r[cots_pkg::CI_PHF] == '0);
      end

      // RULE8 RULE9 RULE10 RULE11
      db_tick = (db_st_r == cots_pkg::DB_RISE) ?
                unit_tick(ctrl_r.rise_deadband_src_sel, DELAY_CHAIN_TICK) :
                unit_tick(ctrl_r.fall_deadband_src_sel, DELAY_CHAIN_TICK);
      prim_nxt = prim_r;
      comp_nxt = comp_r;
      db_nxt = db_r;
      db_st_nxt = db_st_r;
      if (rise_go) begin
         comp_nxt = 1'b0;
         if (cnt_r[cots_pkg::CI_DBR] == '0) begin
            prim_nxt = 1'b1;
            db_st_nxt = cots_pkg::DB_IDLE;
            db_nxt = '0;
         end else begin
            db_nxt = cnt_r[cots_pkg::CI_DBR]; // RULE8
            db_st_nxt = cots_pkg::DB_RISE;
         end
      end else if (fall_go) begin
         prim_nxt = 1'b0;
         if (cnt_r[cots_pkg::CI_DBF] == '0) begin
            comp_nxt = 1'b1;
            db_st_nxt = cots_pkg::DB_IDLE;
            db_nxt = '0;
         end else begin
            db_nxt = cnt_r[cots_pkg::CI_DBF]; // RULE10
            db_st_nxt = cots_pkg::DB_FALL;
         end
      end else if (db_st_r != cots_pkg::DB_IDLE && db_tick) begin
         db_nxt = db_r - 1'b1;
         if (db_r == CNT_W'(1)) begin
            db_st_nxt = cots_pkg::DB_IDLE;
            case (db_st_r)
               cots_pkg::DB_RISE: prim_nxt = 1'b1; // RULE8 RULE9
               cots_pkg::DB_FALL: comp_nxt = 1'b1; // RULE10 RULE11
               default: db_st_nxt = cots_pkg::DB_IDLE;
            endcase
         end
      end

      // shutdown drops the waveform to inactive and forgets pending edges
      if (sd_r) begin
         prim_nxt = 1'b0;
         comp_nxt = 1'b0;
         db_nxt = '0;
         db_st_nxt = cots_pkg::DB_IDLE;
         rph_nxt = '0;
         fph_nxt = '0;
      end

      ev = '0;
      ev[cots_pkg::EV_SHUTDOWN] = sd_nxt & ~sd_r;
      ev[cots_pkg::EV_RISE] = rise_acc;
      ev[cots_pkg::EV_FALL] = fall_acc;
   end

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         sd_r <= 1'b0;
         rblk_r <= '0;
         fblk_r <= '0;
         rph_r <= '0;
         fph_r <= '0;
         db_r <= '0;
         db_st_r <= cots_pkg::DB_IDLE;
         prim_r <= 1'b0;
         comp_r <= 1'b0;
      end else begin
         sd_r <= sd_nxt; // RULE19
         rblk_r <= rblk_nxt;
         fblk_r <= fblk_nxt;
         rph_r <= rph_nxt;
         fph_r <= fph_nxt;
         db_r <= db_nxt;
         db_st_r <= db_st_nxt;
         prim_r <= prim_nxt;
         comp_r <= comp_nxt;
      end
   end

   // ---------------- output pins ----------------

   // a and c carry the primary, b and d the complementary waveform
   assign wave = {comp_r, prim_r, comp_r, prim_r};

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin_nxt[i] = pin_drive(sd_r,
                                (i % 2 == 0) ? ctrl_r.override_level_ac :
                                               ctrl_r.override_level_bd,
                                ctrl_r.polarity[i],
                                steer_r[cots_pkg::STR_LSB + i],
                                steer_r[cots_pkg::SDAT_LSB + i],
                                wave[i]);
      end
   end

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         out_r <= 4'h0;
         oe_r <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            out_r[i] <= pin_nxt[i].lvl;
            oe_r[i] <= pin_nxt[i].oe;
         end
      end
   end

   assign OUTPUT_A = out_r[0];
   assign OUTPUT_B = out_r[1];
   assign OUTPUT_C = out_r[2];
   assign OUTPUT_D = out_r[3];
   assign OUTPUT_A_OE = oe_r[0];
   assign OUTPUT_B_OE = oe_r[1];
   assign OUTPUT_C_OE = oe_r[2];
   assign OUTPUT_D_OE = oe_r[3];
   assign SHUTDOWN_ACTIVE = sd_r;
   assign IRQ = irq_r;
   assign PREADY = pready_r;
   assign PSLVERR = pslverr_r;
   assign PRDATA = prdata_r;

endmodule : cots_top

// File: tb_top.sv
// self-checking bench for the timing and steering block
`timescale 1ns/1ns
module tb_top;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} cots_row_type;
   logic clk, nrst, psel, pen, pwr, rise, fall, tick, prdy, perr, sda, irq, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] src, pins, oes, gate;
   int n_fail, samples_checked, cyc, n;
   cots_row_type rows [7] = '{'{8'h00, 32'hff, 32'h0f, 1'b0}, '{8'h08, 32'ha5, 32'ha5, 1'b0},
      '{8'h04, 32'hffffffff, 32'hfcf, 1'b0}, '{8'h0c, 32'hff, 32'h3f, 1'b0},
      '{8'h20, 32'hc1, 32'h01, 1'b0}, '{8'h30, 32'hff, 32'h0, 1'b1},
      '{8'h0e, 32'hff, 32'h0, 1'b1}};
   logic [7:0] sv [4] = '{8'h50, 8'ha0, 8'hf0, 8'h00};
   logic [5:0] wv [4][4] = '{'{6'h00, 6'h00, 6'h00, 6'h00}, '{6'h00, 6'h03, 6'h00, 6'h05},
      '{6'h02, 6'h01, 6'h04, 6'h00}, '{6'h3f, 6'h02, 6'h01, 6'h3f}};
   cots_top i_dut (.CLK_SYS(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(prdy), .PSLVERR(perr),
      .RISE_EVENT(rise), .FALL_EVENT(fall), .DELAY_CHAIN_TICK(tick),
      .LOGIC_CELL_TWO_OUT(src[3]), .COMPARATOR_TWO_OUT(src[2]), .COMPARATOR_ONE_OUT(src[1]),
      .SELECTED_PIN_IN(src[0]), .OUTPUT_A(pins[0]), .OUTPUT_B(pins[1]), .OUTPUT_C(pins[2]),
      .OUTPUT_D(pins[3]), .OUTPUT_A_OE(oes[0]), .OUTPUT_B_OE(oes[1]), .OUTPUT_C_OE(oes[2]),
      .OUTPUT_D_OE(oes[3]), .SHUTDOWN_ACTIVE(sda), .IRQ(irq));
   cots_gate_drv i_gate (.clk_sys(clk), .pin(pins), .oe(oes), .gate(gate));
   task automatic end_of_test();
      $display("checked %0d bad %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic tend(input string s);
      $display("end of %s, bad so far %0d", s, n_fail);
   endtask : tend
   task automatic wt(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : wt
   // the request stands until pready is seen; read data is taken on that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         t++;
      end while (prdy !== 1'b1 && t < 20);
      if (prdy !== 1'b1) begin
         n_fail++;
         $display("BAD %0t no ready", $time);
      end
      rd = prdata;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic setc(input logic [35:0] v);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, cots_pkg::OFS_CNT0 + cots_pkg::OFS_CNT_STEP * 8'(i), {26'h0, v[i*6 +: 6]});
      end
   endtask : setc
   // edges from the accepting edge until the watched output goes high, capped at lim
   task automatic meas(input logic r, input int lim);
      @(posedge clk);
      if (r) rise <= 1'b1;
      else fall <= 1'b1;
      @(posedge clk);
      rise <= 1'b0;
      fall <= 1'b0;
      n = 0;
      do begin
         wt(1);
         n++;
      end while ((r ? pins[0] : pins[1]) !== 1'b1 && n < lim);
   endtask : meas
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         n_fail++;
         end_of_test();
      end
   end
   initial begin
      {nrst, psel, pen, pwr, rise, fall, tick, paddr, pwdata} = '0;
      src = 4'hf;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      wt(2);
      chk(32'({oes, pins}), 32'hf0);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].w);
         chk(32'(er), 32'(rows[i].e));
         apb(1'b0, rows[i].a, 32'h0);
         chk(rd, rows[i].r);
      end
      tend("registers");
      foreach (sv[i]) begin
         apb(1'b1, cots_pkg::OFS_STEER, 32'(sv[i]));
         wt(2);
         chk(32'(pins), 32'(sv[i][7:4]));
      end
      tend("static levels");
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, cots_pkg::OFS_SD_EN, 32'(~(4'h1 << i)));
         src <= ~(4'h1 << i);
         wt(3);
         chk(32'(sda), 32'h0);
         apb(1'b1, cots_pkg::OFS_SD_EN, 32'(4'h1 << i));
         wt(2);
         chk(32'(sda), 32'h1);
         @(posedge clk);
         src <= 4'hf;
      end
      tend("shutdown sources");
      apb(1'b1, cots_pkg::OFS_CTRL, 32'hb00);
      apb(1'b1, cots_pkg::OFS_IRQ_MASK, 32'h0);
      apb(1'b1, cots_pkg::OFS_IRQ_STS, 32'h7);
      src <= 4'h7;
      wt(4);
      chk(32'(gate), 32'h5);
      chk(32'(irq), 32'h0);
      apb(1'b1, cots_pkg::OFS_IRQ_MASK, 32'h1);
      wt(2);
      chk(32'(irq), 32'h1);
      apb(1'b1, cots_pkg::OFS_CTRL, 32'h00f);
      wt(3);
      chk(32'(pins), 32'hf);
      apb(1'b1, cots_pkg::OFS_CTRL, 32'h100);
      wt(3);
      chk(32'(oes & 4'h5), 32'h0);
      apb(1'b1, cots_pkg::OFS_CTRL, 32'h0);
      src <= 4'hf;
      wt(3);
      chk(32'(sda), 32'h0);
      apb(1'b1, cots_pkg::OFS_IRQ_STS, 32'h1);
      wt(2);
      chk(32'(irq), 32'h0);
      tend("override and interrupt");
      apb(1'b1, cots_pkg::OFS_SD_EN, 32'h0);
      apb(1'b1, cots_pkg::OFS_STEER, 32'h83);
      foreach (wv[j]) begin
         setc({wv[j][2], wv[j][0], 12'h0, wv[j][3], wv[j][1]});
         meas(1'b1, 200);
         chk(n, 32'(wv[j][0]) + 32'(wv[j][1]) + 32'h1);
         meas(1'b0, 200);
         chk(n, 32'(wv[j][2]) + 32'(wv[j][3]) + 32'h1);
      end
      apb(1'b1, cots_pkg::OFS_CTRL, 32'h003);
      wt(3);
      chk(32'(pins), 32'h9);
      apb(1'b1, cots_pkg::OFS_CTRL, 32'h0c0);
      setc({24'h0, 6'h4, 6'h4});
      tend("dead-band and phase");
      for (int k = 1; k >= 0; k--) begin
         @(posedge clk);
         tick <= 1'b0;
         meas(k[0], 12);
         chk(n, 32'hc);
         @(posedge clk);
         tick <= 1'b1;
         wt(8);
         chk(32'(pins[1 - k]), 32'h1);
      end
      apb(1'b1, cots_pkg::OFS_CTRL, 32'h0);
      setc({12'h0, 6'h6, 6'h6, 12'h0});
      tend("delay chain");
      for (int k = 1; k >= 0; k--) begin
         meas(k[0], 20);
         meas(!k[0], 6);
         chk(n, 32'h6);
         meas(!k[0], 20);
         chk(n, 32'h1);
      end
      apb(1'b0, cots_pkg::OFS_IRQ_STS, 32'h0);
      chk(rd, 32'h6);
      apb(1'b0, cots_pkg::OFS_STATE, 32'h0);
      chk(rd, 32'h2);
      tend("blanking");
      apb(1'b1, cots_pkg::OFS_CNT0, 32'h25);
      nrst <= 1'b0;
      wt(2);
      @(posedge clk);
      nrst <= 1'b1;
      apb(1'b0, cots_pkg::OFS_CNT0, 32'h0);
      chk(rd, 32'h25);
      apb(1'b0, cots_pkg::OFS_STEER, 32'h0);
      chk(rd, 32'h0);
      tend("second reset");
      end_of_test();
   end
endmodule : tb_top
